// ### iscu_pkg.sv
package iscu_pkg;
  localparam int unsigned REG_WIDTH = 32;
  localparam int unsigned IDX_WIDTH = 5;
  localparam int unsigned IMM_WIDTH = 16;
  localparam int unsigned OP_WIDTH = 3;
  localparam logic [4:0] ZERO_INDEX = 5'h00;
  localparam logic [4:0] SHAMT_IDLE = 5'h00;
  localparam logic [4:0] SHAMT_BREAK = 5'h01;
  localparam logic [31:0] RESULT_RST = 32'h00000000;
  localparam logic [4:0] DEST_RST = 5'h00;

  typedef enum logic [2:0] {
    ISCU_SHIFT_LEFT_FIXED = 3'b000,
    ISCU_SHIFT_LEFT_VARIABLE = 3'b001,
    ISCU_SHIFT_RIGHT_ARITH = 3'b010,
    ISCU_SET_LESS_SIGNED = 3'b011,
    ISCU_SET_LESS_UNSIGNED = 3'b100,
    ISCU_SET_LESS_SIGNED_IMM = 3'b101,
    ISCU_SET_LESS_UNSIGNED_IMM = 3'b110,
    ISCU_OP_NONE = 3'b111
  } iscu_op_t;

  typedef struct packed {
    logic valid;
    iscu_op_t op;
    logic [4:0] first_source_index;
    logic [4:0] second_source_index;
    logic [4:0] dest_index;
    logic [4:0] shift_amount_field;
    logic [15:0] immediate;
    logic [31:0] first_source_data;
    logic [31:0] second_source_data;
  } iscu_req_t;

  typedef struct packed {
    logic write_en;
    logic [4:0] dest_index;
    logic [31:0] data;
    logic no_operation_idiom;
    logic issue_break;
    logic overflow;
  } iscu_rsp_t;
endpackage

// ### iscu_shifter.sv
`timescale 1ns/1ns
module iscu_shifter (
  input wire logic [31:0] word_in,
  input wire logic [4:0] amount,
  input wire logic arith_right,
  output logic [31:0] word_out
);
  always_comb
  begin
    if (arith_right)
    begin
      word_out = $signed(word_in) >>> amount;
    end
    else
    begin
      word_out = word_in << amount;
    end
  end
endmodule // iscu_shifter

// ### iscu_core.sv
`timescale 1ns/1ns
module iscu_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire iscu_pkg::iscu_req_t req,
  output iscu_pkg::iscu_rsp_t rsp
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] imm_ext;
  logic [31:0] cmp_b;
  logic [4:0] amount;
  logic arith_right;
  logic [31:0] shifted;
  logic less_signed;
  logic less_unsigned;
  logic is_cmp_signed;
  logic is_cmp_unsigned;
  logic is_shift;
  logic idiom_fixed;
  iscu_pkg::iscu_rsp_t rsp_reg;
  iscu_pkg::iscu_rsp_t rsp_next;

  assign imm_ext = {{(32 - 16){req.immediate[15]}}, req.immediate};
  assign is_cmp_signed = (req.op == iscu_pkg::ISCU_SET_LESS_SIGNED)
    || (req.op == iscu_pkg::ISCU_SET_LESS_SIGNED_IMM);
  assign is_cmp_unsigned = (req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED)
    || (req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM);
  assign is_shift = (req.op == iscu_pkg::ISCU_SHIFT_LEFT_FIXED)
    || (req.op == iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE)
    || (req.op == iscu_pkg::ISCU_SHIFT_RIGHT_ARITH);
  assign cmp_b = ((req.op == iscu_pkg::ISCU_SET_LESS_SIGNED_IMM)
    || (req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM)) ? imm_ext : req.second_source_data;
  // Magnitude compare only; no subtract, so no overflow path exists
  assign less_signed = $signed(req.first_source_data) < $signed(cmp_b);
  assign less_unsigned = req.first_source_data < cmp_b;
  assign amount = (req.op == iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE) ?
    req.first_source_data[4:0] : req.shift_amount_field;
  assign arith_right = (req.op == iscu_pkg::ISCU_SHIFT_RIGHT_ARITH);
  assign idiom_fixed = (req.op == iscu_pkg::ISCU_SHIFT_LEFT_FIXED)
    && (req.second_source_index == iscu_pkg::ZERO_INDEX)
    && (req.dest_index == iscu_pkg::ZERO_INDEX);

  iscu_shifter i_iscu_shifter (
    .word_in(req.second_source_data),
    .amount(amount),
    .arith_right(arith_right),
    .word_out(shifted)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    rsp_next = '0;
    rsp_next.dest_index = (req.op == iscu_pkg::ISCU_SET_LESS_SIGNED_IMM)
      || (req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM) ?
      req.second_source_index : req.dest_index;
    if (req.valid)
    begin
      if (is_shift)
      begin
        rsp_next.data = shifted;
      end
      else if (is_cmp_signed)
      begin
        rsp_next.data = {31'h00000000, less_signed};
      end
      else if (is_cmp_unsigned)
      begin
        rsp_next.data = {31'h00000000, less_unsigned};
      end
      rsp_next.no_operation_idiom = idiom_fixed
        && ((req.shift_amount_field == iscu_pkg::SHAMT_IDLE)
        || (req.shift_amount_field == iscu_pkg::SHAMT_BREAK));
      rsp_next.issue_break = idiom_fixed
        && (req.shift_amount_field == iscu_pkg::SHAMT_BREAK);
      // Register zero is never written, so it keeps reading zero
      rsp_next.write_en = (is_shift || is_cmp_signed || is_cmp_unsigned)
        && (rsp_next.dest_index != iscu_pkg::ZERO_INDEX);
      rsp_next.overflow = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_reg <= '0;
    end
    else if (clk_en)
    begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  AST_FIXED_SHIFT_RESULT: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_LEFT_FIXED)
    |=> (rsp.data == ($past(req.second_source_data) << $past(req.shift_amount_field))))
    else $error("fixed left shift result wrong");

  AST_VAR_SHIFT_COUNT: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE)
    |=> (rsp.data == ($past(req.second_source_data) << $past(req.first_source_data[4:0]))))
    else $error("variable shift count wrong");

  AST_VAR_SHIFT_ZEROFILL: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE
    && req.first_source_data[4:0] != 5'h00) |=> (rsp.data[0] == 1'b0))
    else $error("variable shift low bit not zero");

  AST_SRA_SIGN: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_RIGHT_ARITH)
    |=> (rsp.data[31] == $past(req.second_source_data[31])))
    else $error("arithmetic shift sign lost");

  AST_IDLE_NOWRITE: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && idiom_fixed && req.shift_amount_field == 5'h00)
    |=> (!rsp.write_en && rsp.no_operation_idiom && !rsp.issue_break))
    else $error("idle idiom not recognised");

  AST_BREAK: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && idiom_fixed && req.shift_amount_field == 5'h01)
    |=> (!rsp.write_en && rsp.issue_break))
    else $error("issue break idiom not flagged");

  AST_LESS_SIGNED: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_SIGNED)
    |=> (rsp.data == {31'h00000000,
    $past($signed(req.first_source_data) < $signed(req.second_source_data))}))
    else $error("signed compare wrong");

  AST_NO_OVF: assert property (@(posedge clk) disable iff (rst)
    !rsp.overflow) else $error("overflow raised");

  AST_LESS_SIGNED_IMM_DEST: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_SIGNED_IMM)
    |=> (rsp.dest_index == $past(req.second_source_index)))
    else $error("immediate compare destination wrong");

  AST_LESS_UNSIGNED_IMM: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM)
    |=> (rsp.data[0] == $past(req.first_source_data < imm_ext)))
    else $error("unsigned immediate compare wrong");

  AST_LESS_UNSIGNED: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED)
    |=> (rsp.data == {31'h00000000,
    $past(req.first_source_data < req.second_source_data)}))
    else $error("unsigned compare wrong");

  AST_ZERO_DEST: assert property (@(posedge clk) disable iff (rst)
    rsp.write_en |-> (rsp.dest_index != 5'h00))
    else $error("write to register zero");

  ////////////////////////////////////////////////////////////////////////////////
  // Expectations below are built from the operands, not from the datapath signals
  AST_HOLD_WHEN_FROZEN: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(rsp))
    else $error("response moved while clock enable low");

  AST_RESET_CLEAR: assert property (@(posedge clk)
    (rst && $past(rst)) |-> (rsp == '0))
    else $error("response not cleared in reset");

  AST_REFUSE_NONE: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_OP_NONE)
    |=> (!rsp.write_en && rsp.data == 32'h00000000))
    else $error("undefined operation produced a write");

  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !req.valid)
    |=> (!rsp.write_en && rsp.data == 32'h00000000
    && !rsp.no_operation_idiom && !rsp.issue_break))
    else $error("idle cycle produced a response");

  AST_FIXED_ZERO_PASS: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_LEFT_FIXED
    && req.shift_amount_field == 5'h00)
    |=> (rsp.data == $past(req.second_source_data)))
    else $error("fixed zero shift altered the word");

  AST_VAR_ZERO_PASS: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE
    && req.first_source_data[4:0] == 5'h00)
    |=> (rsp.data == $past(req.second_source_data)))
    else $error("variable zero shift altered the word");

  AST_ARITH_ZERO_PASS: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_RIGHT_ARITH
    && req.shift_amount_field == 5'h00)
    |=> (rsp.data == $past(req.second_source_data)))
    else $error("arithmetic zero shift altered the word");

  AST_FIXED_ZEROFILL: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_LEFT_FIXED
    && req.shift_amount_field != 5'h00)
    |=> (rsp.data[0] == 1'b0))
    else $error("fixed shift low bit not zero");

  AST_VAR_HIGH_IGNORED: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE
    && req.first_source_data[31:5] != 27'h0000000)
    |=> (rsp.data == ($past(req.second_source_data) << $past(req.first_source_data[4:0]))))
    else $error("variable shift used high count bits");

  AST_ARITH_FILL: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_RIGHT_ARITH
    && req.shift_amount_field != 5'h00)
    |=> (rsp.data[30] == $past(req.second_source_data[31])))
    else $error("arithmetic shift fill wrong");

  AST_ARITH_VALUE: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_RIGHT_ARITH)
    |=> (rsp.data ==
    $past(32'($signed(req.second_source_data) >>> req.shift_amount_field))))
    else $error("arithmetic shift result wrong");

  AST_ARITH_LOW: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SHIFT_RIGHT_ARITH)
    |=> (rsp.data[0] == $past(req.second_source_data[req.shift_amount_field])))
    else $error("arithmetic shift low bit wrong");

  AST_SHIFT_WRITE: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.dest_index != 5'h00
    && req.op inside {iscu_pkg::ISCU_SHIFT_LEFT_FIXED, iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE,
    iscu_pkg::ISCU_SHIFT_RIGHT_ARITH})
    |=> rsp.write_en)
    else $error("shift result not written");

  AST_SHIFT_DEST: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op inside {iscu_pkg::ISCU_SHIFT_LEFT_FIXED,
    iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE, iscu_pkg::ISCU_SHIFT_RIGHT_ARITH})
    |=> (rsp.dest_index == $past(req.dest_index)))
    else $error("shift destination wrong");

  AST_REG_CMP_WRITE: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.dest_index != 5'h00 && req.op inside
    {iscu_pkg::ISCU_SET_LESS_SIGNED, iscu_pkg::ISCU_SET_LESS_UNSIGNED})
    |=> (rsp.write_en && rsp.dest_index == $past(req.dest_index)))
    else $error("register compare not written");

  AST_IMM_CMP_WRITE: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.second_source_index != 5'h00 && req.op inside
    {iscu_pkg::ISCU_SET_LESS_SIGNED_IMM, iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM})
    |=> rsp.write_en)
    else $error("immediate compare not written");

  AST_CMP_ONE_BIT: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op inside
    {iscu_pkg::ISCU_SET_LESS_SIGNED, iscu_pkg::ISCU_SET_LESS_UNSIGNED,
    iscu_pkg::ISCU_SET_LESS_SIGNED_IMM, iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM})
    |=> (rsp.data[31:1] == 31'h00000000))
    else $error("compare result not zero extended");

  AST_LESS_SIGNED_IMM: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_SIGNED_IMM)
    |=> (rsp.data == {31'h00000000, $past($signed(req.first_source_data)
    < $signed({{16{req.immediate[15]}}, req.immediate}))}))
    else $error("signed immediate compare wrong");

  AST_UNSIGNED_IMM_DEST: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM)
    |=> (rsp.dest_index == $past(req.second_source_index)))
    else $error("unsigned immediate destination wrong");

  AST_UNSIGNED_IMM_HIGH: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM
    && req.immediate[15] && req.first_source_data < 32'hFFFF8000)
    |=> (rsp.data == 32'h00000001))
    else $error("negative immediate not treated as large");

  AST_UNSIGNED_IMM_LOW: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM
    && !req.immediate[15] && req.first_source_data[31:15] != 17'h00000)
    |=> (rsp.data == 32'h00000000))
    else $error("small immediate compare wrong");

  AST_SIGNED_NEG_POS: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_SIGNED
    && req.first_source_data[31] && !req.second_source_data[31])
    |=> (rsp.data == 32'h00000001))
    else $error("negative not below positive");

  AST_UNSIGNED_REG_TOP: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op == iscu_pkg::ISCU_SET_LESS_UNSIGNED
    && req.first_source_data[31] && !req.second_source_data[31])
    |=> (rsp.data == 32'h00000000))
    else $error("top bit not treated as magnitude");

  AST_BREAK_IS_IDLE: assert property (@(posedge clk) disable iff (rst)
    rsp.issue_break |-> rsp.no_operation_idiom)
    else $error("issue break without idle idiom");

  AST_IDIOM_ONLY_FIXED: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.op != iscu_pkg::ISCU_SHIFT_LEFT_FIXED)
    |=> (!rsp.no_operation_idiom && !rsp.issue_break))
    else $error("idiom flagged on other operation");

  AST_IDIOM_WIDE_SHIFT: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid && req.shift_amount_field > 5'h01)
    |=> (!rsp.no_operation_idiom && !rsp.issue_break))
    else $error("idiom flagged on wide shift");

  AST_IDIOM_NONZERO_REG: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req.valid
    && (req.second_source_index != 5'h00 || req.dest_index != 5'h00))
    |=> !rsp.no_operation_idiom)
    else $error("idiom flagged on live registers");
endmodule // iscu_core

// ### iscu_regfile_model.sv
`timescale 1ns/1ns
module iscu_regfile_model (
  input wire logic clk,
  input wire logic [4:0] rd_a,
  input wire logic [4:0] rd_b,
  input wire iscu_pkg::iscu_rsp_t rsp,
  output logic [31:0] data_a,
  output logic [31:0] data_b
);
  logic [31:0] mem [32];
  // Register zero is hardwired, whatever was written
  assign data_a = (rd_a == 5'h00) ? 32'h00000000 : mem[rd_a];
  assign data_b = (rd_b == 5'h00) ? 32'h00000000 : mem[rd_b];
  always @(posedge clk)
  begin
    if (rsp.write_en === 1'b1)
    begin
      mem[rsp.dest_index] <= rsp.data;
    end
  end
endmodule // iscu_regfile_model

// ### integer_shift_compare_unit_tb.sv
`timescale 1ns/1ns
module integer_shift_compare_unit_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  iscu_pkg::iscu_req_t cmd = '0;
  iscu_pkg::iscu_req_t req;
  iscu_pkg::iscu_rsp_t rsp;
  logic [31:0] data_a;
  logic [31:0] data_b;
  int bad_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  always_comb
  begin
    req = cmd;
    req.first_source_data = data_a;
    req.second_source_data = data_b;
  end
  iscu_core i_iscu_core (.clk(clk), .rst(rst), .clk_en(clk_en), .req(req), .rsp(rsp));
  iscu_regfile_model i_iscu_regfile_model (.clk(clk), .rd_a(cmd.first_source_index),
    .rd_b(cmd.second_source_index), .rsp(rsp), .data_a(data_a), .data_b(data_b));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input iscu_pkg::iscu_op_t op, input logic [4:0] a, input logic [4:0] b,
    input logic [4:0] d, input logic [4:0] amt, input logic [15:0] imm,
    input logic [31:0] e, input logic we);
    logic [4:0] dst;
    dst = d;
    if (op == iscu_pkg::ISCU_SET_LESS_SIGNED_IMM || op == iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM)
      dst = b;
    @(posedge clk);
    cmd <= '{1'b1, op, a, b, d, amt, imm, 32'h00000000, 32'h00000000};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
    chk("data", e, rsp.data);
    chk("write_en", {31'h0, we}, {31'h0, rsp.write_en});
    chk("overflow", 32'h0, {31'h0, rsp.overflow});
    if (we)
      chk("dest", {27'h0, dst}, {27'h0, rsp.dest_index});
  endtask
  task automatic t_shift;
    run(iscu_pkg::ISCU_SHIFT_LEFT_FIXED, 0, 2, 6, 4, 0, 32'h00000010, 1);
    run(iscu_pkg::ISCU_SHIFT_LEFT_FIXED, 0, 4, 7, 0, 0, 32'h7FFFFFFF, 1);
    run(iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE, 3, 1, 8, 0, 0, 32'h00000010, 1);
    run(iscu_pkg::ISCU_SHIFT_LEFT_VARIABLE, 0, 2, 8, 0, 0, 32'h80000001, 1);
    run(iscu_pkg::ISCU_SHIFT_RIGHT_ARITH, 0, 2, 9, 4, 0, 32'hF8000000, 1);
    run(iscu_pkg::ISCU_SHIFT_RIGHT_ARITH, 0, 2, 9, 31, 0, 32'hFFFFFFFF, 1);
  endtask
  task automatic t_compare;
    run(iscu_pkg::ISCU_SET_LESS_SIGNED, 2, 1, 10, 0, 0, 32'h00000001, 1);
    run(iscu_pkg::ISCU_SET_LESS_SIGNED, 4, 2, 10, 0, 0, 32'h00000000, 1);
    run(iscu_pkg::ISCU_SET_LESS_UNSIGNED, 2, 1, 11, 0, 0, 32'h00000000, 1);
    run(iscu_pkg::ISCU_SET_LESS_UNSIGNED, 1, 2, 11, 0, 0, 32'h00000001, 1);
    run(iscu_pkg::ISCU_SET_LESS_SIGNED_IMM, 2, 12, 3, 0, 16'h0000, 32'h00000001, 1);
    run(iscu_pkg::ISCU_SET_LESS_SIGNED_IMM, 1, 12, 3, 0, 16'hFFFF, 32'h00000000, 1);
    run(iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM, 4, 13, 3, 0, 16'hFFFF, 32'h00000001, 1);
    run(iscu_pkg::ISCU_SET_LESS_UNSIGNED_IMM, 5, 13, 3, 0, 16'h7FFF, 32'h00000000, 1);
  endtask
  task automatic t_idiom;
    run(iscu_pkg::ISCU_SHIFT_LEFT_FIXED, 0, 0, 0, 0, 0, 32'h00000000, 0);
    chk("idle idiom", 32'h1, {31'h0, rsp.no_operation_idiom});
    chk("break", 32'h0, {31'h0, rsp.issue_break});
    run(iscu_pkg::ISCU_SHIFT_LEFT_FIXED, 0, 0, 0, 1, 0, 32'h00000000, 0);
    chk("break", 32'h1, {31'h0, rsp.issue_break});
    // Shift by two is no idiom, yet register zero still must not be written
    run(iscu_pkg::ISCU_SHIFT_LEFT_FIXED, 0, 0, 0, 2, 0, 32'h00000000, 0);
    chk("idle idiom", 32'h0, {31'h0, rsp.no_operation_idiom});
  endtask
  task automatic t_refuse;
    run(iscu_pkg::ISCU_OP_NONE, 2, 2, 6, 4, 0, 32'h00000000, 0);
    run(iscu_pkg::ISCU_SET_LESS_SIGNED, 2, 1, 0, 0, 0, 32'h00000001, 0);
    @(posedge clk);
    #1;
    chk("idle data", 32'h00000000, rsp.data);
    chk("idle write_en", 32'h00000000, {31'h0, rsp.write_en});
  endtask
  task automatic t_hold;
    @(posedge clk);
    cmd <= '{1'b1, iscu_pkg::ISCU_SHIFT_LEFT_FIXED, 5'h00, 5'h02, 5'h06, 5'h04, 16'h0000,
      32'h00000000, 32'h00000000};
    @(posedge clk);
    // Second request waits while the enable is low
    clk_en <= 1'b0;
    cmd.second_source_index <= 5'h04;
    cmd.dest_index <= 5'h07;
    cmd.shift_amount_field <= 5'h00;
    repeat (2) @(posedge clk);
    #1;
    chk("held data", 32'h00000010, rsp.data);
    chk("held write_en", 32'h00000001, {31'h0, rsp.write_en});
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
    chk("resumed data", 32'h7FFFFFFF, rsp.data);
  endtask
  task automatic t_reset;
    run(iscu_pkg::ISCU_SET_LESS_SIGNED, 2, 1, 10, 0, 0, 32'h00000001, 1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset data", 32'h00000000, rsp.data);
    chk("reset write_en", 32'h00000000, {31'h0, rsp.write_en});
    @(posedge clk);
    rst <= 1'b0;
    run(iscu_pkg::ISCU_SHIFT_LEFT_FIXED, 0, 1, 6, 1, 0, 32'h00000002, 1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_iscu_regfile_model.mem[1] = 32'h00000001;
    i_iscu_regfile_model.mem[2] = 32'h80000001;
    // High bits set so a full-width count would differ from the low five bits
    i_iscu_regfile_model.mem[3] = 32'hFFFFFFE4;
    i_iscu_regfile_model.mem[4] = 32'h7FFFFFFF;
    i_iscu_regfile_model.mem[5] = 32'h00008000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_shift();
    t_compare();
    t_idiom();
    t_refuse();
    t_hold();
    t_reset();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
endmodule // integer_shift_compare_unit_tb
